// ==== dv/dllc_core_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// **********
// Bench for the lock loop core
// **********
module dllc_core_bench;
  logic clk;
  logic rstn;
  dllc_pkg::dllc_regbus_s bus;
  dllc_pkg::dllc_profile_s prof;
  dllc_pkg::dllc_pins_s pins;
  dllc_pkg::dllc_mode_e mode;
  logic new_ref;
  logic signed [47:0] drift;
  logic ref_edge;
  logic fb_rollover;
  logic [47:0] ref_tdc;
  logic [47:0] fb_time;
  logic [7:0] rdata;
  logic [47:0] tuning_word;
  logic phase_locked;
  logic freq_locked;
  int bad_count;
  int n_tests;
  dllc_core DUT (.clk(clk), .rstn(rstn), .bus(bus), .prof(prof), .pins(pins), .mode(mode),
    .new_ref(new_ref), .ref_edge(ref_edge), .ref_tdc(ref_tdc), .fb_rollover(fb_rollover),
    .fb_time(fb_time), .rdata(rdata), .tuning_word(tuning_word), .phase_locked(phase_locked),
    .freq_locked(freq_locked));
  dllc_ref_model partner (.clk(clk), .rstn(rstn), .drift(drift), .ref_edge(ref_edge),
    .ref_tdc(ref_tdc), .fb_rollover(fb_rollover), .fb_time(fb_time));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("bad_count=%0d n_tests=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Byte write, strobe held for exactly one edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk) bus <= '0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk) bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) bus <= '0;
    #1;
    chk(rdata, exp);
  endtask
  // Bounded wait for {freq, phase} lock; a timeout ends the run
  task automatic wait_lk(input logic [1:0] exp);
    #1;
    for (int i = 0; i < 4000 && {freq_locked, phase_locked} !== exp; i++) begin
      @(posedge clk);
      #1;
    end
    chk(8'({freq_locked, phase_locked}), 8'(exp));
    if ({freq_locked, phase_locked} !== exp) stop_test();
  endtask
  task automatic pulse_pins(input dllc_pkg::dllc_pins_s p);
    @(posedge clk) pins <= p;
    @(posedge clk) pins <= '0;
  endtask
  task automatic t_reset;
    rd_chk(12'ha10, 8'h00);
    rd_chk(12'h316, 8'h00);
    rd_chk(12'h123, 8'h00);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 5; i++) wr(12'h30f + 12'(i), 8'ha0 + 8'(i));
    wr(12'h314, 8'h88);
    wr(12'h315, 8'h13);
    for (int i = 0; i < 5; i++) rd_chk(12'h30f + 12'(i), 8'ha0 + 8'(i));
    rd_chk(12'h314, 8'h88);
    rd_chk(12'h315, 8'h13);
    // Offset back to zero so aligned edges can lock
    for (int i = 0; i < 5; i++) wr(12'h30f + 12'(i), 8'h00);
  endtask
  // Step of 5000 ps is well past the 1000 ps threshold
  task automatic t_offset;
    pulse_pins('{1'b1, 1'b0, 1'b0});
    wait_lk(2'b10);
    wr(12'ha0c, 8'h04);
    wait_lk(2'b11);
    wr(12'ha0c, 8'h02);
    rd_chk(12'ha0c, 8'h00);
    wait_lk(2'b10);
    pulse_pins('{1'b0, 1'b0, 1'b1});
    wait_lk(2'b11);
    wr(12'ha0c, 8'h01);
    wait_lk(2'b10);
    chk(tuning_word, 48'hffff_ffff_ec78);
    wr(12'ha0c, 8'h04);
    wait_lk(2'b11);
    pulse_pins('{1'b0, 1'b1, 1'b0});
    wait_lk(2'b10);
    chk(tuning_word, 48'h0000_0000_1388);
    pulse_pins('{1'b0, 1'b0, 1'b1});
    wait_lk(2'b11);
  endtask
  task automatic t_switch;
    @(posedge clk) mode <= dllc_pkg::DLLC_SWITCHING;
    drift <= 48'sd3000;
    repeat (400) @(posedge clk);
    #1;
    chk(8'({freq_locked, phase_locked}), 8'h03);
    @(posedge clk) mode <= dllc_pkg::DLLC_CLOSED;
    wait_lk(2'b00);
  endtask
  task automatic t_freerun;
    @(posedge clk) mode <= dllc_pkg::DLLC_FREERUN;
    drift <= 48'sd0;
    repeat (200) @(posedge clk);
    #1;
    chk(8'({freq_locked, phase_locked}), 8'h00);
    @(posedge clk) mode <= dllc_pkg::DLLC_HOLDOVER;
    repeat (200) @(posedge clk);
    #1;
    chk(8'({freq_locked, phase_locked}), 8'h00);
    @(posedge clk) mode <= dllc_pkg::DLLC_CLOSED;
    wait_lk(2'b11);
    @(posedge clk) new_ref <= 1'b1;
    @(posedge clk) new_ref <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(8'(phase_locked), 8'h00);
  endtask
  initial begin
    rstn = 1'b0;
    bus = '0;
    pins = '0;
    mode = dllc_pkg::DLLC_CLOSED;
    new_ref = 1'b0;
    drift = '0;
    bad_count = 0;
    n_tests = 0;
    prof = '0;
    prof.s_div = 30'h7;
    prof.v_den = 10'h1;
    prof.phase_thresh = 16'h03e8;
    prof.freq_thresh = 24'h0003e8;
    // Alpha of one half times two: filter output equals the error
    prof.alpha_frac = 16'h8000;
    prof.alpha_pos1 = 4'h1;
    {prof.p_fill, prof.p_drain, prof.f_fill, prof.f_drain} = 32'hffffffff;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_regs();
    wait_lk(2'b11);
    rd_chk(12'ha10, 8'h03);
    t_offset();
    t_switch();
    t_freerun();
    stop_test();
  end
endmodule
`default_nettype wire

// ==== dv/dllc_core_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// **********
// Lock detector and register checks
// **********
module dllc_core_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire dllc_pkg::dllc_regbus_s bus,
  input wire dllc_pkg::dllc_mode_e mode,
  input wire logic new_ref,
  input wire logic ref_edge,
  input wire logic [7:0] rdata,
  input wire logic phase_locked,
  input wire logic freq_locked
);
  // Reference edges since the tubs were last emptied
  logic [4:0] nsmp;
  logic empty_ev;
  assign empty_ev = new_ref || mode inside {dllc_pkg::DLLC_FREERUN, dllc_pkg::DLLC_HOLDOVER};
  // Saturates, so a long run never wraps back under the bound
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nsmp <= 5'h00;
    end else if (empty_ev) begin
      nsmp <= 5'h00;
    end else if (ref_edge && nsmp != 5'h1f) begin
      nsmp <= nsmp + 5'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_ctrl_clear;
    $past(bus.rd) && $past(bus.addr) == 12'ha0c |-> rdata[2:0] == 3'h0;
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear) else $error("control bit read back set");
  property p_status;
    $past(bus.rd) && $past(bus.addr) == 12'ha10
      |-> rdata[1:0] == {$past(freq_locked), $past(phase_locked)};
  endproperty
  a_status: assert property (p_status) else $error("status differs from lock outputs");
  property p_freerun;
    $past(mode) inside {dllc_pkg::DLLC_FREERUN, dllc_pkg::DLLC_HOLDOVER}
      |-> !phase_locked && !freq_locked;
  endproperty
  a_freerun: assert property (p_freerun) else $error("lock shown outside closed loop");
  property p_hold_p;
    $past(mode) == dllc_pkg::DLLC_SWITCHING && !$past(new_ref) |-> $stable(phase_locked);
  endproperty
  a_hold_p: assert property (p_hold_p) else $error("phase lock moved in switchover");
  property p_hold_f;
    $past(mode) == dllc_pkg::DLLC_SWITCHING && !$past(new_ref) |-> $stable(freq_locked);
  endproperty
  a_hold_f: assert property (p_hold_f) else $error("freq lock moved in switchover");
  property p_rise_closed;
    $rose(phase_locked) || $rose(freq_locked) |-> $past(mode) == dllc_pkg::DLLC_CLOSED;
  endproperty
  a_rise_closed: assert property (p_rise_closed) else $error("lock rose outside closed loop");
  property p_fill_p;
    $rose(phase_locked) |-> nsmp >= 5'd12;
  endproperty
  a_fill_p: assert property (p_fill_p) else $error("phase lock rose too soon");
  property p_fill_f;
    $rose(freq_locked) |-> nsmp >= 5'd12;
  endproperty
  a_fill_f: assert property (p_fill_f) else $error("freq lock rose too soon");
  property p_new_ref;
    new_ref && mode == dllc_pkg::DLLC_CLOSED |-> ##[1:3] !phase_locked;
  endproperty
  a_new_ref: assert property (p_new_ref) else $error("lock kept after new reference");
endmodule
bind dllc_core dllc_core_checker u_chk (.clk(clk), .rstn(rstn), .bus(bus), .mode(mode),
  .new_ref(new_ref), .ref_edge(ref_edge), .rdata(rdata), .phase_locked(phase_locked),
  .freq_locked(freq_locked));
`default_nettype wire

// ==== dv/dllc_ref_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// **********
// Reference edge and feedback rollover source
// **********
module dllc_ref_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic signed [47:0] drift,
  output logic ref_edge,
  output logic [47:0] ref_tdc,
  output logic fb_rollover,
  output logic [47:0] fb_time
);
  logic [47:0] t;
  logic [47:0] n;
  logic [3:0] ph;
  // One edge pair each 16 cycles; feedback slips by n times drift
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {t, n, ph} <= '0;
      {ref_edge, ref_tdc, fb_rollover, fb_time} <= '0;
    end else begin
      t <= t + 48'h1f40;
      ph <= ph + 4'h1;
      ref_edge <= ph == 4'h0;
      fb_rollover <= ph == 4'h0;
      if (ph == 4'h0) begin
        ref_tdc <= t;
        fb_time <= t + n * drift;
        n <= n + 48'h1;
      end else begin
        // Stamps mean nothing between edges, so show junk
        ref_tdc <= ~t;
        fb_time <= t ^ 48'h5a5a;
      end
    end
  end
endmodule
`default_nettype wire

// ==== hdl/dllc_core.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dllc_params.svh"
module dllc_core #(
  parameter int TW_W = 48
) (
  input wire logic clk,
  input wire logic rstn,
  input wire dllc_pkg::dllc_regbus_s bus,
  input wire dllc_pkg::dllc_profile_s prof,
  input wire dllc_pkg::dllc_pins_s pins,
  input wire dllc_pkg::dllc_mode_e mode,
  input wire logic new_ref,
  input wire logic ref_edge,
  input wire logic [TW_W-1:0] ref_tdc,
  input wire logic fb_rollover,
  input wire logic [TW_W-1:0] fb_time,
  output logic [7:0] rdata,
  output logic [TW_W-1:0] tuning_word,
  output logic phase_locked,
  output logic freq_locked
);

  // ************************************************************
  // Helpers
  // ************************************************************

  // These helpers serve the filter and both
  // lock detectors, so each sum is written and sized once.

  // Magnitude of a signed word
  // The most negative word maps onto itself; an error that
  // large means the loop is far out of range, and the tub
  // drains either way.
  function automatic logic [47:0] mag(input logic signed [47:0] v);
    mag = v[47] ? 48'(-v) : 48'(v);
  endfunction

  // Coefficient product: fraction (Q16) scaled by 2^-x
  // A leading zero keeps the fraction positive in the signed
  // product. The product is 64 bits wide so nothing wraps
  // before the arithmetic shift, which keeps the sign.
  // Rounding toward minus infinity leaves a bias well below
  // one picosecond per sample, which the integrators absorb.
  function automatic logic signed [47:0] coef(input logic signed [47:0] v,
      input logic [15:0] frac, input logic [4:0] neg);
    logic signed [63:0] p;
    p = 64'(v) * $signed({1'b0, frac});
    coef = 48'(p >>> (6'd16 + 6'(neg)));
  endfunction

  // Saturating tub update
  // One bucket per error sample, fill or drain, never both.
  // The sum is one bit wider than the level, so a full bucket
  // on a full tub cannot wrap before the clamp.
  function automatic logic signed [13:0] tub(input logic signed [13:0] lvl,
      input logic fill, input logic [7:0] up, input logic [7:0] down);
    logic signed [14:0] n;
    n = fill ? 15'(lvl) + 15'($signed({1'b0, up}))
             : 15'(lvl) - 15'($signed({1'b0, down}));
    if (n > 15'(`DLLC_TUB_FULL)) tub = `DLLC_TUB_FULL;
    else if (n < 15'(`DLLC_TUB_EMPTY)) tub = `DLLC_TUB_EMPTY;
    else tub = 14'(n);
  endfunction

  // Hysteretic indication
  // Between the marks the old flag is kept, so a level that
  // hovers near one mark cannot make the flag chatter.
  function automatic logic hyst(input logic signed [13:0] lvl, input logic prev);
    if (lvl > `DLLC_TUB_HIGH) hyst = 1'b1;
    else if (lvl < `DLLC_TUB_LOW) hyst = 1'b0;
    else hyst = prev;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  dllc_pkg::dllc_state_s st; // Registered state
  dllc_pkg::dllc_state_s next_st; // Next state
  // All state lives in one packed struct: the process below
  // builds the whole next value and one flip-flop process
  // registers it. Fields left alone keep their value because
  // the copy starts from the current state.

  // Next-state logic
  // Sections run in order: requests, offset, dividers, phase
  // detector, filter, lock flags, read data. Each section but
  // the lock flags reads registered state only, so those stages add one
  // cycle of latency; at the divided reference rate that is
  // far below one sample period.
  always_comb begin
    // Working values; each gets a value first so no latch can
    // form and nothing is left over from an earlier pass.
    logic inc_req;
    logic dec_req;
    logic clr_req;
    logic signed [41:0] target;
    logic signed [41:0] diff;
    logic signed [47:0] e;
    logic signed [47:0] a;
    logic signed [47:0] pdiff;
    inc_req = 1'b0;
    dec_req = 1'b0;
    clr_req = 1'b0;
    target = '0;
    diff = '0;
    e = '0;
    a = '0;
    pdiff = '0;
    next_st = st;
    // Strobes last one cycle: cleared here, set below only on
    // the cycle of their event.
    next_st.err_valid = 1'b0;
    next_st.ref_tick = 1'b0;
    next_st.fb_tick = 1'b0;

    // Register writes; control bits act once and never store
    // Wide registers change a byte at a time; a live offset
    // passes through its intermediate values, which the slew
    // limiter then smooths when it is enabled.
    if (bus.wr) begin
      if (bus.addr >= `DLLC_ADDR_FIXED_OFS && bus.addr <= `DLLC_ADDR_FIXED_OFS_LAST) begin
        // Byte k sits at the base address plus k, low byte first
        next_st.fixed_ofs[8*(bus.addr - `DLLC_ADDR_FIXED_OFS) +: 8] = bus.wdata;
      end
      unique case (bus.addr)
        `DLLC_ADDR_STEP: next_st.step[7:0] = bus.wdata;
        `DLLC_ADDR_STEP_HI: next_st.step[15:8] = bus.wdata;
        `DLLC_ADDR_SLEW: next_st.slew[7:0] = bus.wdata;
        `DLLC_ADDR_SLEW_HI: next_st.slew[15:8] = bus.wdata;
        `DLLC_ADDR_PHASE_CTRL: begin
          // Each set bit is a request for this cycle only; nothing
          // is stored, which is what makes the bits self-clearing.
          inc_req = bus.wdata[`DLLC_BIT_INC];
          dec_req = bus.wdata[`DLLC_BIT_DEC];
          clr_req = bus.wdata[`DLLC_BIT_CLR];
        end
        default: begin
          // Other addresses belong elsewhere
        end
      endcase
    end
    // Pin-driven actions merge with register actions
    // A pin pulse and a write in one cycle count once; inc and
    // dec together cancel, and a clear beats both.
    inc_req = inc_req | pins.inc;
    dec_req = dec_req | pins.dec;
    clr_req = clr_req | pins.clr;

    // Incremental offset kept apart from the fixed offset
    // Two bits wider than the fixed offset so that many steps
    // on a large fixed offset do not wrap; software should
    // clear it long before it nears the limit.
    if (clr_req) begin
      next_st.incr_ofs = '0;
    end else if (inc_req && !dec_req) begin
      next_st.incr_ofs = st.incr_ofs + 42'($signed({1'b0, st.step}));
    end else if (dec_req && !inc_req) begin
      next_st.incr_ofs = st.incr_ofs - 42'($signed({1'b0, st.step}));
    end

    // Offset actually applied; slewed one step per sample when limited
    // With a zero limit the target passes straight through.
    // Otherwise the applied offset moves by at most the limit
    // per error sample, so a jump in either offset becomes a
    // ramp instead of a phase hit. The limit is per sample,
    // not per second: a coarse stand-in for a rate limiter
    // that the user scales to the sample rate.
    target = 42'($signed(st.fixed_ofs)) + st.incr_ofs;
    diff = target - st.applied_ofs;
    if (st.slew == `DLLC_SLEW_RESET) begin
      next_st.applied_ofs = target;
    end else if (st.err_valid) begin
      if (diff > 42'($signed({1'b0, st.slew}))) begin
        next_st.applied_ofs = st.applied_ofs + 42'($signed({1'b0, st.slew}));
      end else if (diff < -42'($signed({1'b0, st.slew}))) begin
        next_st.applied_ofs = st.applied_ofs - 42'($signed({1'b0, st.slew}));
      end else begin
        next_st.applied_ofs = target;
      end
    end

    // Reference prescaler: one tick every R+1 edges
    // The >= test means lowering R on the fly cannot strand the
    // count above the new end value. The stamp is latched only
    // on the dividing edge; other stamps mean nothing.
    if (ref_edge) begin
      if (st.rcnt >= prof.r_div) begin
        next_st.rcnt = '0;
        next_st.ref_tick = 1'b1;
        next_st.ref_word = $signed(ref_tdc);
      end else begin
        next_st.rcnt = st.rcnt + 30'h1;
      end
    end

    // Feedback divider: S+1 rollovers, one extra when fraction overflows
    // U is added each tick and wraps at V; each wrap stretches
    // the next division by one rollover, S+1+U/V on average.
    // A zero V turns the fraction off instead of dividing by 0.
    if (fb_rollover) begin
      if (st.scnt >= prof.s_div + 30'(st.extra)) begin
        next_st.scnt = '0;
        next_st.fb_tick = 1'b1;
        next_st.fb_word = $signed(fb_time);
        // Fractional accumulator, modulo V
        if (prof.v_den != 10'h0 && 11'(st.frac_acc) + 11'(prof.u_num) >= 11'(prof.v_den)) begin
          next_st.frac_acc = 10'(11'(st.frac_acc) + 11'(prof.u_num) - 11'(prof.v_den));
          next_st.extra = 1'b1;
        end else begin
          next_st.frac_acc = st.frac_acc + prof.u_num;
          next_st.extra = 1'b0;
        end
      end else begin
        next_st.scnt = st.scnt + 30'h1;
      end
    end

    // Reference waits for its feedback partner
    // Both ticks come at the same average rate; a reference
    // tick is held until its feedback tick arrives and the pair
    // gives one error sample. A second reference tick first
    // just replaces the stamp, so the newest edge is compared.
    // The pump term is the instant error and the integrator
    // keeps the running sum, a digital pump and hold capacitor.
    if (st.ref_tick) next_st.ref_seen = 1'b1;
    if (st.fb_tick && (st.ref_seen || st.ref_tick)) begin
      // Time difference less offset; the extra-cycle residue is removed
      // by adding the fractional accumulator frac_acc itself, not scaled by V
      e = st.ref_word - st.fb_word - 48'(st.applied_ofs)
          + 48'(st.frac_acc);
      // Period difference between the inputs since the last
      // sample; zero when both run at one rate, whatever phase.
      pdiff = (st.ref_word - st.prev_ref) - (st.fb_word - st.prev_fb);
      next_st.prev_ref = st.ref_word;
      next_st.prev_fb = st.fb_word;
      next_st.perr = pdiff;
      next_st.pump = e;
      next_st.err = st.err + e;
      next_st.err_valid = 1'b1;
      next_st.ref_seen = 1'b0;
    end

    // Third-order IIR: alpha scaled up by two positive exponents
    // Alpha is the proportional path; beta and gamma integrate
    // and delta scales. The two exponents are widened before
    // they are summed so their carry is kept. Every stage
    // advances only on an error sample.
    if (st.err_valid) begin
      a = coef(st.pump, prof.alpha_frac, prof.alpha_neg)
          <<< (5'(prof.alpha_pos1) + 5'(prof.alpha_pos2));
      next_st.i1 = st.i1 + coef(st.pump, prof.beta_frac, prof.beta_neg);
      next_st.i2 = st.i2 + coef(st.i1, prof.gamma_frac, prof.gamma_neg);
      // Last stage: a plain scaling of the second integrator
      next_st.i3 = coef(st.i2, prof.delta_frac, prof.delta_neg);
      next_st.tw = a + st.i1 + st.i3;
      // Lock detectors, one bucket per sample
      // The phase tub judges the instant error; the frequency
      // tub judges the period difference, so a steady offset
      // fills it while a drifting phase drains it.
      next_st.ptub = tub(st.ptub, mag(st.pump) <= 48'(prof.phase_thresh),
                         prof.p_fill, prof.p_drain);
      next_st.ftub = tub(st.ftub, mag(st.perr) <= 48'(prof.freq_thresh),
                         prof.f_fill, prof.f_drain);
    end

    // Indications follow the tub with hysteresis, per mode
    // Free-run and holdover drop both flags and empty both
    // tubs, so closed loop must earn lock again. In switchover
    // the flags freeze while the tubs keep tracking, which can
    // hide a short bad patch from the user.
    unique case (mode)
      dllc_pkg::DLLC_CLOSED: begin
        // The new level is used so the flag moves in the cycle
        // the level crosses a mark, not one cycle later.
        next_st.plock = hyst(next_st.ptub, st.plock);
        next_st.flock = hyst(next_st.ftub, st.flock);
      end
      dllc_pkg::DLLC_FREERUN, dllc_pkg::DLLC_HOLDOVER: begin
        next_st.plock = 1'b0;
        next_st.flock = 1'b0;
        next_st.ptub = `DLLC_TUB_EMPTY;
        next_st.ftub = `DLLC_TUB_EMPTY;
      end
      dllc_pkg::DLLC_SWITCHING: begin
        next_st.plock = st.plock;
        next_st.flock = st.flock;
      end
    endcase
    // A fresh reference restarts the tubs; indication is held
    // In closed loop the flags fall on the next cycle, since an empty tub is
    // below the low mark.
    if (new_ref) begin
      next_st.ptub = `DLLC_TUB_EMPTY;
      next_st.ftub = `DLLC_TUB_EMPTY;
    end

    // Register read data, registered for a clean output
    // It stands one cycle after the strobe and is zero
    // otherwise, so read data of several blocks can be ORed.
    // Reads have no side effects.
    next_st.rdata = 8'h00;
    if (bus.rd) begin
      if (bus.addr >= `DLLC_ADDR_FIXED_OFS && bus.addr <= `DLLC_ADDR_FIXED_OFS_LAST) begin
        next_st.rdata = st.fixed_ofs[8*(bus.addr - `DLLC_ADDR_FIXED_OFS) +: 8];
      end
      unique case (bus.addr)
        `DLLC_ADDR_STEP: next_st.rdata = st.step[7:0];
        `DLLC_ADDR_STEP_HI: next_st.rdata = st.step[15:8];
        `DLLC_ADDR_SLEW: next_st.rdata = st.slew[7:0];
        `DLLC_ADDR_SLEW_HI: next_st.rdata = st.slew[15:8];
        `DLLC_ADDR_PHASE_CTRL: begin
          // Request bits are never stored
          next_st.rdata = 8'h00;
        end
        `DLLC_ADDR_STATUS: next_st.rdata = {6'h00, st.flock, st.plock};
        default: begin
          // Fixed offset bytes keep the value set above; other addresses read zero
        end
      endcase
    end
  end

  // State register; tubs start empty so the loop reports unlock
  // Reset zeroes every field but the tubs, which start at the
  // empty mark; a zero level would sit between the marks and
  // leave the flags depending on a history that does not
  // exist yet.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.ptub <= `DLLC_TUB_EMPTY;
      st.ftub <= `DLLC_TUB_EMPTY;
    end else begin
      // The whole state advances together; no field has an enable
      st <= next_st;
    end
  end

  // ************************************************************
  // Outputs straight from flip-flops
  // ************************************************************
  // Each output is a state field, so nothing combinational
  // stands between a flip-flop and a pin.
  assign rdata = st.rdata;
  assign tuning_word = TW_W'(st.tw);
  assign phase_locked = st.plock;
  assign freq_locked = st.flock;

endmodule
`default_nettype wire

// ==== hdl/dllc_params.svh ====
`ifndef DLLC_PARAMS_SVH
`define DLLC_PARAMS_SVH
// ************************************************************
// Register byte addresses
// ************************************************************
`define DLLC_ADDR_FIXED_OFS 12'h30f
`define DLLC_ADDR_FIXED_OFS_LAST 12'h313
`define DLLC_ADDR_STEP 12'h314
`define DLLC_ADDR_STEP_HI 12'h315
`define DLLC_ADDR_SLEW 12'h316
`define DLLC_ADDR_SLEW_HI 12'h317
`define DLLC_ADDR_PHASE_CTRL 12'ha0c
`define DLLC_ADDR_STATUS 12'ha10
// ************************************************************
// Control bit positions
// ************************************************************
`define DLLC_BIT_INC 0
`define DLLC_BIT_DEC 1
`define DLLC_BIT_CLR 2
// Status bit positions
`define DLLC_BIT_PLOCK 0
`define DLLC_BIT_FLOCK 1
// ************************************************************
// Lock detector tub limits
// ************************************************************
`define DLLC_TUB_EMPTY (-14'sd2048)
`define DLLC_TUB_FULL (14'sd2048)
`define DLLC_TUB_LOW (-14'sd1024)
`define DLLC_TUB_HIGH (14'sd1024)
// Slew limit value that turns the limiter off, so the target passes straight through
`define DLLC_SLEW_RESET 16'h0000
`endif

// ==== hdl/dllc_pkg.sv ====
package dllc_pkg;
  // Mode of the loop
  typedef enum logic [1:0] {
    DLLC_CLOSED = 2'b00,
    DLLC_FREERUN = 2'b01,
    DLLC_HOLDOVER = 2'b10,
    DLLC_SWITCHING = 2'b11
  } dllc_mode_e;
  // Active profile fields
  typedef struct packed {
    logic [29:0] r_div;
    logic [29:0] s_div;
    logic [9:0] u_num;
    logic [9:0] v_den;
    logic [15:0] phase_thresh;
    logic [23:0] freq_thresh;
    logic [7:0] p_fill;
    logic [7:0] p_drain;
    logic [7:0] f_fill;
    logic [7:0] f_drain;
    logic [4:0] alpha_neg;
    logic [3:0] alpha_pos1;
    logic [3:0] alpha_pos2;
    logic [15:0] alpha_frac;
    logic [15:0] beta_frac;
    logic [4:0] beta_neg;
    logic [15:0] gamma_frac;
    logic [4:0] gamma_neg;
    logic [15:0] delta_frac;
    logic [4:0] delta_neg;
  } dllc_profile_s;
  // Register read and write port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dllc_regbus_s;
  // Multifunction pin actions
  typedef struct packed {
    logic inc;
    logic dec;
    logic clr;
  } dllc_pins_s;
  // Whole block state
  typedef struct packed {
    logic [39:0] fixed_ofs;
    logic [15:0] step;
    logic [15:0] slew;
    logic signed [41:0] incr_ofs;
    logic signed [41:0] applied_ofs;
    logic [29:0] rcnt;
    logic ref_tick;
    logic [29:0] scnt;
    logic [9:0] frac_acc;
    logic extra;
    logic fb_tick;
    logic signed [47:0] ref_word;
    logic ref_seen;
    logic signed [47:0] pump;
    logic signed [47:0] err;
    logic err_valid;
    logic signed [47:0] prev_ref;
    logic signed [47:0] prev_fb;
    logic signed [47:0] fb_word;
    logic signed [47:0] perr;
    logic signed [47:0] i1;
    logic signed [47:0] i2;
    logic signed [47:0] i3;
    logic signed [47:0] tw;
    logic signed [13:0] ptub;
    logic signed [13:0] ftub;
    logic plock;
    logic flock;
    logic [7:0] rdata;
  } dllc_state_s;
endpackage
